// ### chg_cfg.svh
`ifndef CHG_CFG_SVH
`define CHG_CFG_SVH

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define CHG_IDX_TERM 6'h04
`define CHG_IDX_VBAT 6'h05
`define CHG_IDX_SYS 6'h06
`define CHG_IDX_STAT 6'h0c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CHG_RST_TERM 8'h0e
`define CHG_RST_VBAT 8'h78
`define CHG_RST_SYS 8'hb8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CHG_TERM_RANGE_BIT 7
`define CHG_TERM_CODE_HI 6
`define CHG_TERM_CODE_LO 2
`define CHG_TERM_EN_BIT 1
`define CHG_VBAT_CODE_HI 7
`define CHG_VBAT_CODE_LO 1
`define CHG_SYS_EN_BIT 7
`define CHG_OUTPUT_RANGE_SELECT_HI 6
`define CHG_OUTPUT_RANGE_SELECT_LO 5
`define CHG_SYS_CODE_HI 4
`define CHG_SYS_CODE_LO 1

// ----------------------------------------
// Setpoint arithmetic (uA and mV)
// ----------------------------------------
`define CHG_TERM_LO_OFS_UA 16'h01f4
`define CHG_TERM_LO_STEP_UA 16'h01f4
`define CHG_TERM_LO_MAX_UA 16'h1388
`define CHG_TERM_HI_OFS_UA 16'h1770
`define CHG_TERM_HI_STEP_UA 16'h03e8
`define CHG_VBAT_BASE_MV 13'h0e10
`define CHG_VBAT_STEP_MV 13'h000a
`define CHG_VBAT_MAX_MV 13'h122a
`define CHG_SYS_BASE01_MV 12'h514
`define CHG_SYS_BASE11_MV 12'h708
`define CHG_SYS_STEP_MV 12'h064

`endif

// ### chg_pkg.sv
package chg_pkg;

  typedef logic [7:0] chg_byte_t;
  typedef logic [15:0] chg_ua_t;
  typedef logic [12:0] chg_vbat_t;
  typedef logic [11:0] chg_mv_t;

  typedef enum logic [1:0] {
    CHG_RANGE_LOW,
    CHG_RANGE_MID,
    CHG_RANGE_ALT,
    CHG_RANGE_HIGH
  } chg_sel_e;

  typedef enum logic [1:0] {
    CHG_BUS_IDLE,
    CHG_BUS_WAIT,
    CHG_BUS_DONE
  } chg_bus_e;

endpackage

// ### chg_sys_lut.sv
`timescale 1ns/100ps
`default_nettype none
`include "chg_cfg.svh"

module chg_sys_lut
  import chg_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [1:0] rangeSel, // Output range select
  input wire logic [3:0] voltCode, // Output voltage code
  output chg_mv_t voltMv // Registered setpoint in mV
);

  // ----------------------------------------
  // Nonlinear families as a constant table
  // ----------------------------------------
  function automatic chg_mv_t tableMv(input logic hiFam, input logic [3:0] c);
    chg_mv_t lo;
    chg_mv_t hi;
    unique case (c)
      4'h0: begin lo = 12'h44c; hi = 12'h5dc; end
      4'h1: begin lo = 12'h4b0; hi = 12'h62f; end
      4'h2: begin lo = 12'h4e2; hi = 12'h683; end
      4'h3: begin lo = 12'h535; hi = 12'h6d6; end
      4'h4: begin lo = 12'h589; hi = 12'h729; end
      4'h5: begin lo = 12'h5dc; hi = 12'h77d; end
      4'h6: begin lo = 12'h62f; hi = 12'h7d0; end
      4'h7: begin lo = 12'h683; hi = 12'h823; end
      4'h8: begin lo = 12'h6d6; hi = 12'h877; end
      4'h9: begin lo = 12'h729; hi = 12'h8ca; end
      4'ha: begin lo = 12'h77d; hi = 12'h91d; end
      4'hb: begin lo = 12'h7d0; hi = 12'h971; end
      4'hc: begin lo = 12'h823; hi = 12'h9c4; end
      4'hd: begin lo = 12'h877; hi = 12'ha17; end
      4'he: begin lo = 12'h8ca; hi = 12'ha6b; end
      4'hf: begin lo = 12'h91d; hi = 12'habe; end
    endcase
    return hiFam ? hi : lo;
  endfunction

  function automatic chg_mv_t linMv(input chg_mv_t base, input logic [3:0] c);
    return base + chg_mv_t'(c) * `CHG_SYS_STEP_MV;
  endfunction

  chg_mv_t next_voltMv;

  always_comb begin
    unique case (chg_sel_e'(rangeSel))
      CHG_RANGE_LOW: next_voltMv = tableMv(1'b0, voltCode);
      CHG_RANGE_MID: next_voltMv = linMv(`CHG_SYS_BASE01_MV, voltCode);
      CHG_RANGE_ALT: next_voltMv = tableMv(1'b1, voltCode);
      CHG_RANGE_HIGH: next_voltMv = linMv(`CHG_SYS_BASE11_MV, voltCode);
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      voltMv <= linMv(`CHG_SYS_BASE01_MV, 4'hc);
    end else begin
      voltMv <= next_voltMv;
    end
  end

endmodule

`default_nettype wire

// ### chg_setpoint_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "chg_cfg.svh"

module chg_setpoint_regs
  import chg_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ccLoopActive, // Constant current loop in control
  input wire logic cvLoopActive, // Constant voltage loop in control
  input wire logic inputLimitLoop, // Input voltage limit loop in control
  input wire logic coolReduction, // Cool temperature reduction active
  input wire logic extTermValid, // External termination resistor fitted
  input wire chg_ua_t extTermUa, // External termination current, uA
  output chg_ua_t termCurrentUa, // Effective termination current, uA
  output logic termAllowed, // Termination may fire now
  output chg_vbat_t batRegMv, // Effective battery regulation, mV
  output logic sysOutEnable, // Switching output enabled
  output logic sysOutPullLow, // Output actively pulled low
  output chg_mv_t sysOutMv // System output setpoint, mV
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Low address bits must be zero; a byte-offset access is refused
  function automatic logic addrHit(input logic [7:0] a, input logic [5:0] idx);
    return (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic chg_ua_t termUa(input logic hiRange, input logic [4:0] c);
    chg_ua_t raw;
    if (hiRange) begin
      raw = `CHG_TERM_HI_OFS_UA + chg_ua_t'(c) * `CHG_TERM_HI_STEP_UA;
    end else begin
      raw = `CHG_TERM_LO_OFS_UA + chg_ua_t'(c) * `CHG_TERM_LO_STEP_UA;
    end
    // Only the effective value saturates; the stored code stays as written
    if (!hiRange && raw > `CHG_TERM_LO_MAX_UA) begin
      raw = `CHG_TERM_LO_MAX_UA;
    end
    return raw;
  endfunction

  function automatic chg_vbat_t vbatMv(input logic [6:0] c);
    chg_vbat_t raw;
    raw = `CHG_VBAT_BASE_MV + chg_vbat_t'(c) * `CHG_VBAT_STEP_MV;
    if (raw > `CHG_VBAT_MAX_MV) begin
      raw = `CHG_VBAT_MAX_MV;
    end
    return raw;
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Term and battery writes keep the whole byte, system writes drop bit 0; only the decoded outputs are bounded
  chg_byte_t termReg;
  chg_byte_t vbatReg;
  chg_byte_t sysReg;
  chg_bus_e busState;
  chg_bus_e next_busState;

  logic accessPhase;
  logic commit;
  logic writeCommit;
  logic hitTerm;
  logic hitVbat;
  logic hitSys;
  logic hitStat;
  logic hitAny;

  assign accessPhase = psel && penable;
  assign hitTerm = addrHit(paddr, `CHG_IDX_TERM);
  assign hitVbat = addrHit(paddr, `CHG_IDX_VBAT);
  assign hitSys = addrHit(paddr, `CHG_IDX_SYS);
  assign hitStat = addrHit(paddr, `CHG_IDX_STAT);
  assign hitAny = hitTerm || hitVbat || hitSys || hitStat;

  // Write lands at the edge where the master samples pready high
  assign commit = accessPhase && pready;
  assign writeCommit = commit && pwrite;

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  // Ready is registered, so every access takes one wait cycle;
  // the trade buys a flop-driven pready and prdata.
  always_comb begin
    next_busState = busState;
    unique case (busState)
      CHG_BUS_IDLE: begin
        if (accessPhase) begin
          next_busState = CHG_BUS_WAIT;
        end
      end
      CHG_BUS_WAIT: begin
        next_busState = CHG_BUS_DONE;
      end
      CHG_BUS_DONE: begin
        next_busState = CHG_BUS_IDLE;
      end
      // The fourth code of the state word is unused; fall back to idle
      default: begin
        next_busState = CHG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busState <= CHG_BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_busState == CHG_BUS_WAIT);
    end
  end

  // Refusal rides on the ready cycle; a refused write changes nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= (next_busState == CHG_BUS_WAIT) && !hitAny;
    end
  end

  // ----------------------------------------
  // Termination and pre-charge register
  // ----------------------------------------
  // The reset byte sets the enable and a low current code of three
  always_ff @(posedge clk) begin
    if (srst) begin
      termReg <= `CHG_RST_TERM;
    end else if (writeCommit && hitTerm) begin
      termReg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Battery regulation register
  // ----------------------------------------
  // Bit 0 is stored and read back but never decoded
  always_ff @(posedge clk) begin
    if (srst) begin
      vbatReg <= `CHG_RST_VBAT;
    end else if (writeCommit && hitVbat) begin
      vbatReg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // System output register
  // ----------------------------------------
  // Bit 0 has no storage here and always reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      sysReg <= `CHG_RST_SYS;
    end else if (writeCommit && hitSys) begin
      sysReg <= {pwdata[7:1], 1'b0};
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  // Bit 0 of each register is never decoded
  logic termRangeHi;
  logic [4:0] termCode;
  logic termEnable;
  logic [6:0] batCode;
  logic outEnable;
  logic [1:0] outRange;
  logic [3:0] outCode;

  assign termRangeHi = termReg[`CHG_TERM_RANGE_BIT];
  assign termCode = termReg[`CHG_TERM_CODE_HI:`CHG_TERM_CODE_LO];
  assign termEnable = termReg[`CHG_TERM_EN_BIT];
  assign batCode = vbatReg[`CHG_VBAT_CODE_HI:`CHG_VBAT_CODE_LO];
  assign outEnable = sysReg[`CHG_SYS_EN_BIT];
  assign outRange = sysReg[`CHG_OUTPUT_RANGE_SELECT_HI:`CHG_OUTPUT_RANGE_SELECT_LO];
  assign outCode = sysReg[`CHG_SYS_CODE_HI:`CHG_SYS_CODE_LO];

  // ----------------------------------------
  // Termination setpoint
  // ----------------------------------------
  chg_ua_t regTermUa;
  logic termClamped;
  logic onlyMainLoops;

  assign regTermUa = termUa(termRangeHi, termCode);
  // Clamp flag feeds status only; the setpoint path saturates by itself
  assign termClamped = !termRangeHi && (regTermUa == `CHG_TERM_LO_MAX_UA)
                       && (termCode > 5'h09);

  // Any loop besides constant current or constant voltage blocks it
  // An input voltage limit or a cool-temperature cut both count as foreign
  assign onlyMainLoops = (ccLoopActive || cvLoopActive)
                         && !inputLimitLoop && !coolReduction;

  // A fitted resistor wins while present; the register value returns
  // on the first edge after it goes away
  always_ff @(posedge clk) begin
    if (srst) begin
      termCurrentUa <= termUa(1'b0, 5'h03);
    end else if (extTermValid) begin
      termCurrentUa <= extTermUa;
    end else begin
      termCurrentUa <= regTermUa;
    end
  end

  // Registered like the setpoints, so the gate trails its inputs by one edge
  always_ff @(posedge clk) begin
    if (srst) begin
      termAllowed <= 1'b0;
    end else begin
      termAllowed <= termEnable && onlyMainLoops;
    end
  end

  // ----------------------------------------
  // Battery regulation setpoint
  // ----------------------------------------
  logic batClamped;

  // Code 105 lands exactly on the ceiling, so only larger codes clamp
  assign batClamped = (batCode > 7'h69);

  always_ff @(posedge clk) begin
    if (srst) begin
      batRegMv <= vbatMv(7'h3c);
    end else begin
      batRegMv <= vbatMv(batCode);
    end
  end

  // ----------------------------------------
  // System output control
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sysOutEnable <= 1'b0;
    end else begin
      sysOutEnable <= outEnable;
    end
  end

  // Pull-down is only released while the output is enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      sysOutPullLow <= 1'b1;
    end else begin
      sysOutPullLow <= !outEnable;
    end
  end

  // The lookup owns the only register stage on this path, like the other setpoints
  chg_sys_lut chg_sys_lut_i (
    .clk(clk),
    .srst(srst),
    .rangeSel(outRange),
    .voltCode(outCode),
    .voltMv(sysOutMv)
  );

  // ----------------------------------------
  // Status and read data
  // ----------------------------------------
  // Status: b0 termination allowed, b1 term clamp,
  // b2 battery clamp, b3 external override, b4 output on.
  chg_byte_t statusByte;
  chg_byte_t readByte;

  // Status is live, not latched: a read shows the state of that cycle
  assign statusByte = {3'h0, outEnable, extTermValid, batClamped,
                       termClamped, termEnable && onlyMainLoops};

  always_comb begin
    readByte = 8'h00;
    if (hitTerm) begin
      readByte = termReg;
    end else if (hitVbat) begin
      readByte = vbatReg;
    end else if (hitSys) begin
      readByte = sysReg;
    end else if (hitStat) begin
      readByte = statusByte;
    end
  end

  // Zero outside the answer cycle, so a stale byte never lingers on the bus
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (next_busState == CHG_BUS_WAIT && !pwrite) begin
      prdata <= {24'h00_0000, readByte};
    end else if (next_busState != CHG_BUS_WAIT) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Software keeps termination programmed before any all-ones
  // charge code; this bank relies on that ordering.

endmodule

`default_nettype wire

// ### chg_setpoint_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "chg_cfg.svh"

module chg_setpoint_regs_monitor
  import chg_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [7:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic [31:0] prdata, // APB
  input wire logic pready, // APB
  input wire logic pslverr, // APB
  input wire logic ccLoopActive, // Loop
  input wire logic cvLoopActive, // Loop
  input wire logic inputLimitLoop, // Loop
  input wire logic coolReduction, // Loop
  input wire logic extTermValid, // Override
  input wire chg_ua_t extTermUa, // Override
  input wire chg_ua_t termCurrentUa, // Setpoint
  input wire logic termAllowed, // Gate
  input wire chg_vbat_t batRegMv, // Setpoint
  input wire logic sysOutEnable, // Output
  input wire logic sysOutPullLow, // Output
  input wire chg_mv_t sysOutMv // Setpoint
);
  // ----------------------------------------
  // Shadow bank, fed only by accepted writes
  // ----------------------------------------
  chg_byte_t termReg;
  chg_byte_t vbatReg;
  chg_byte_t sysReg;
  chg_ua_t expTerm;
  chg_vbat_t expBat;
  chg_mv_t expSys;
  logic [31:0] expRd;
  logic [5:0] idx;
  logic mapped;
  logic expGate;
  logic sysEn;
  logic linSel;
  logic lowZero;

  assign idx = paddr[7:2];
  assign mapped = paddr[1:0] == 2'h0 && idx >= `CHG_IDX_TERM && idx <= `CHG_IDX_SYS;
  assign expGate = termReg[1] && (ccLoopActive || cvLoopActive)
    && !inputLimitLoop && !coolReduction;
  assign sysEn = sysReg[7];
  assign linSel = sysReg[5];
  assign lowZero = sysReg[6:1] == 6'h00;
  assign expBat = (vbatReg[7:1] > 7'h69) ? `CHG_VBAT_MAX_MV
    : `CHG_VBAT_BASE_MV + 13'(vbatReg[7:1]) * `CHG_VBAT_STEP_MV;
  assign expSys = (sysReg[6:5] == 2'h3 ? `CHG_SYS_BASE11_MV : `CHG_SYS_BASE01_MV)
    + 12'(sysReg[4:1]) * `CHG_SYS_STEP_MV;

  always_ff @(posedge clk) begin
    if (srst) begin
      termReg <= `CHG_RST_TERM;
      vbatReg <= `CHG_RST_VBAT;
      sysReg <= `CHG_RST_SYS;
    end else if (psel && penable && pready && pwrite && mapped) begin
      case (idx)
        `CHG_IDX_TERM: termReg <= pwdata[7:0];
        `CHG_IDX_VBAT: vbatReg <= pwdata[7:0];
        default: sysReg <= pwdata[7:0];
      endcase
    end
  end

  always_comb begin
    if (extTermValid) expTerm = extTermUa;
    else if (termReg[7]) expTerm = `CHG_TERM_HI_OFS_UA + 16'(termReg[6:2]) * `CHG_TERM_HI_STEP_UA;
    else if (termReg[6:2] > 5'h09) expTerm = `CHG_TERM_LO_MAX_UA;
    else expTerm = `CHG_TERM_LO_OFS_UA + 16'(termReg[6:2]) * `CHG_TERM_LO_STEP_UA;
    case (idx)
      `CHG_IDX_TERM: expRd = {24'h0, termReg};
      `CHG_IDX_VBAT: expRd = {24'h0, vbatReg};
      default: expRd = {24'h0, sysReg[7:1], 1'b0};
    endcase
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_term_setpoint: assert property (
    !$past(srst) |-> termCurrentUa == $past(expTerm)) else $error("termination setpoint wrong");
  a_term_gate: assert property (
    !$past(srst) |-> termAllowed == $past(expGate)) else $error("termination gate wrong");
  a_bat_setpoint: assert property (
    !$past(srst) |-> batRegMv == $past(expBat)) else $error("battery setpoint wrong");
  a_out_enable: assert property (
    !$past(srst) |-> sysOutEnable == $past(sysEn) && sysOutPullLow == !sysOutEnable)
    else $error("output enable or pull-low wrong");
  a_out_linear: assert property (
    !$past(srst) && $past(linSel) |-> sysOutMv == $past(expSys))
    else $error("linear output setpoint wrong");
  a_out_table_base: assert property (
    !$past(srst) && $past(lowZero) |-> sysOutMv == 12'h44c)
    else $error("lowest family start wrong");
  a_read_back: assert property (
    pready && !pwrite && mapped |-> prdata == expRd && !pslverr) else $error("read data wrong");
  a_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("access phase not answered");
  a_ready_pulse: assert property (
    pready |=> !pready ##1 !pready) else $error("ready held too long");

  c_hi_range: cover property (psel && penable && pready && pwrite && mapped && pwdata[7]);
  c_refused: cover property (pready && pslverr);
  c_out_off: cover property ($fell(sysOutEnable));
endmodule

bind chg_setpoint_regs chg_setpoint_regs_monitor chg_setpoint_regs_monitor_i (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .ccLoopActive, .cvLoopActive, .inputLimitLoop, .coolReduction, .extTermValid, .extTermUa,
  .termCurrentUa, .termAllowed, .batRegMv, .sysOutEnable, .sysOutPullLow, .sysOutMv
);
`default_nettype wire

// ### chg_setpoint_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHECK(nm, e, g) \
  checkCount++; \
  if ((g) !== (e)) begin \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
    failures++; \
  end

module chg_setpoint_regs_tb
  import chg_pkg::*;
;
  logic clk;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ccLoopActive;
  logic cvLoopActive;
  logic inputLimitLoop;
  logic coolReduction;
  logic extTermValid;
  chg_ua_t extTermUa;
  chg_ua_t termCurrentUa;
  logic termAllowed;
  chg_vbat_t batRegMv;
  logic sysOutEnable;
  logic sysOutPullLow;
  chg_mv_t sysOutMv;
  int failures;
  int checkCount;
  logic [31:0] rdat;
  logic rerr;
  chg_ua_t expUa;
  chg_mv_t expMv;
  logic [7:0] val;
  logic [4:0] tCodes [4] = '{5'h00, 5'h09, 5'h0a, 5'h1f};
  logic [6:0] bCodes [5] = '{7'h00, 7'h3c, 7'h69, 7'h6a, 7'h7f};
  // Nonlinear families share one ladder; family 10 starts five rungs up
  chg_mv_t nlMv [21] = '{12'h44c, 12'h4b0, 12'h4e2, 12'h535, 12'h589, 12'h5dc, 12'h62f,
    12'h683, 12'h6d6, 12'h729, 12'h77d, 12'h7d0, 12'h823, 12'h877, 12'h8ca, 12'h91d,
    12'h971, 12'h9c4, 12'ha17, 12'ha6b, 12'habe};

  chg_setpoint_regs chg_setpoint_regs_i (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ccLoopActive, .cvLoopActive, .inputLimitLoop, .coolReduction, .extTermValid, .extTermUa,
    .termCurrentUa, .termAllowed, .batRegMv, .sysOutEnable, .sysOutPullLow, .sysOutMv
  );

  always #5 clk = ~clk;

  // ----------------------------------------
  // Bus and timing helpers
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Setpoints and the output table both lag the register by one edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ccLoopActive = 1'b1;
    cvLoopActive = 1'b0;
    inputLimitLoop = 1'b0;
    coolReduction = 1'b0;
    extTermValid = 1'b0;
    extTermUa = 16'h0000;
    failures = 0;
    checkCount = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    settle();
    `CHECK("termCurrentUa", 16'h07d0, termCurrentUa)
    `CHECK("batRegMv", 13'h1068, batRegMv)
    `CHECK("sysOutMv", 12'h9c4, sysOutMv)
    `CHECK("sysOutEnable", 1'b1, sysOutEnable)
    xfer(1'b0, 8'h10, 32'h0);
    `CHECK("termReset", 32'h0000_000e, rdat)
    xfer(1'b0, 8'h14, 32'h0);
    `CHECK("batReset", 32'h0000_0078, rdat)
    xfer(1'b0, 8'h18, 32'h0);
    `CHECK("sysReset", 32'h0000_00b8, rdat)
    `CHECK("sysResetErr", 1'b0, rerr)
    $display("test reset done");

    for (int r = 0; r < 2; r++) begin
      foreach (tCodes[k]) begin
        val = {1'(r), tCodes[k], 2'b11};
        xfer(1'b1, 8'h10, {24'h0, val});
        settle();
        if (r == 1) expUa = 16'h1770 + 16'(tCodes[k]) * 16'h03e8;
        else if (tCodes[k] > 5'h09) expUa = 16'h1388;
        else expUa = 16'h01f4 + 16'(tCodes[k]) * 16'h01f4;
        `CHECK("termCurrentUa", expUa, termCurrentUa)
        xfer(1'b0, 8'h10, 32'h0);
        `CHECK("termReadback", {24'h0, val}, rdat)
      end
    end
    @(posedge clk);
    extTermValid <= 1'b1;
    extTermUa <= 16'h2345;
    settle();
    `CHECK("termOverride", 16'h2345, termCurrentUa)
    @(posedge clk);
    extTermValid <= 1'b0;
    settle();
    `CHECK("termRestored", 16'h9088, termCurrentUa)
    $display("test termination current done");

    for (int te = 0; te < 2; te++) begin
      xfer(1'b1, 8'h10, {24'hdeadbe, 4'h0, 2'b11, 1'(te), 1'b0});
      xfer(1'b0, 8'h10, 32'h0);
      `CHECK("termUpperIgnored", {28'h0, 2'b11, 1'(te), 1'b0}, rdat)
      for (int g = 0; g < 16; g++) begin
        @(posedge clk);
        {ccLoopActive, cvLoopActive, inputLimitLoop, coolReduction} <= 4'(g);
        settle();
        `CHECK("termAllowed", te[0] && (g[3] || g[2]) && !g[1] && !g[0], termAllowed)
      end
    end
    $display("test termination gate done");

    foreach (bCodes[k]) begin
      xfer(1'b1, 8'h14, {24'h0, bCodes[k], 1'b1});
      settle();
      `CHECK("batRegMv", (bCodes[k] > 7'h69) ? 13'h122a : 13'h0e10 + 13'(bCodes[k]) * 13'h000a,
        batRegMv)
      xfer(1'b0, 8'h14, 32'h0);
      `CHECK("batReadback", {24'h0, bCodes[k], 1'b1}, rdat)
    end
    $display("test battery regulation done");

    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 16; c++) begin
        val = {c[0], 2'(s), 4'(c), 1'b1};
        xfer(1'b1, 8'h18, {24'h0, val});
        settle();
        if (s == 0) expMv = nlMv[c];
        else if (s == 2) expMv = nlMv[c + 5];
        else expMv = (s == 3 ? 12'h708 : 12'h514) + 12'(c) * 12'h064;
        `CHECK("sysOutMv", expMv, sysOutMv)
        `CHECK("sysOutEnable", c[0], sysOutEnable)
        `CHECK("sysOutPullLow", !c[0], sysOutPullLow)
        xfer(1'b0, 8'h18, 32'h0);
        `CHECK("sysReadback", {24'h0, val[7:1], 1'b0}, rdat)
      end
    end
    $display("test system output done");

    xfer(1'b1, 8'h1c, 32'h0000_00ff);
    `CHECK("unmappedWrErr", 1'b1, rerr)
    xfer(1'b0, 8'h1c, 32'h0);
    `CHECK("unmappedRdErr", 1'b1, rerr)
    `CHECK("unmappedRdData", 32'h0, rdat)
    xfer(1'b1, 8'h11, 32'h0000_00ff);
    `CHECK("misalignedErr", 1'b1, rerr)
    xfer(1'b0, 8'h10, 32'h0);
    `CHECK("termKept", 32'h0000_000e, rdat)
    $display("test refused access done");

    @(posedge clk);
    {ccLoopActive, cvLoopActive, inputLimitLoop, coolReduction} <= 4'h8;
    xfer(1'b0, 8'h30, 32'h0);
    `CHECK("statusRead", 32'h0000_0015, rdat)
    `CHECK("statusErr", 1'b0, rerr)
    $display("test status done");

    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    settle();
    `CHECK("midResetBatMv", 13'h1068, batRegMv)
    `CHECK("midResetSysMv", 12'h9c4, sysOutMv)
    xfer(1'b0, 8'h14, 32'h0);
    `CHECK("midResetVbat", 32'h0000_0078, rdat)
    xfer(1'b0, 8'h18, 32'h0);
    `CHECK("midResetSys", 32'h0000_00b8, rdat)
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
